// ---- common/adc_cfg_consts.vh ----
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_PORT_CONFIG        8'h00
`define ADDR_CORE0_OFFSET_C     8'h20
`define ADDR_CORE0_OFFSET_F     8'h21
`define ADDR_CORE0_GAIN_C       8'h22
`define ADDR_CORE0_GAIN_M       8'h23
`define ADDR_CORE0_GAIN_F       8'h24
`define ADDR_POWER_STATE        8'h25
`define ADDR_CORE1_OFFSET_C     8'h26
`define ADDR_CORE1_OFFSET_F     8'h27
`define ADDR_CORE1_GAIN_C       8'h28
`define ADDR_CORE1_GAIN_M       8'h29
`define ADDR_CORE1_GAIN_F       8'h2a
`define ADDR_CLOCK_ADVANCE      8'h71
`define ADDR_CLOCK_DIVIDER      8'h72
`define ADDR_FORMAT_A           8'h73
`define ADDR_FORMAT_B           8'h74
`define ADDR_CAL_DONE           8'hb6
`define ADDR_TEST_SELECT        8'hc0
`define ADDR_USER_FIRST         8'hc1
`define ADDR_USER_LAST          8'hd0
`define ADDR_ADJUST_ENABLE      8'hfe

// ****************************************
// Field positions
// ****************************************
`define BIT_SOFT_RESET          5
`define BIT_DLL_SLOW            6
`define BIT_FORMAT_B_RSVD       4

// ****************************************
// Reset values and codes
// ****************************************
`define TRIM_MID                8'h80
`define GAIN_COARSE_ZERO        8'h00
`define REG_ZERO                8'h00
`define PWR_PIN                 3'b000
`define PWR_NORMAL              3'b001
`define PWR_NAP                 3'b010
`define PWR_SLEEP               3'b100
`define DIV_PIN                 3'b000
`define DIV_BY_ONE              3'b001
`define DIV_BY_TWO              3'b010
`define TEST_OFF                4'h0
`define TEST_MID                4'h1
`define TEST_POS                4'h2
`define TEST_NEG                4'h3
`define TEST_USER               4'h8
`define TEST_RAMP               4'ha
`define WORD_MID                16'h8000
`define WORD_POS                16'hffff
`define WORD_NEG                16'h0000

`endif

// ---- hw/adc_config_register_bank.v ----
// Summary of operation
// - Per core 8-bit coarse and fine offset; 0x80 zero, 0x00 min, 0xFF max.
// - Trim registers take self-calibration results after power-up, not constants.
// - Core zero offset writes reach the converter only while adjust-enable is high.
// - Gain trim is 4-bit coarse plus 8-bit medium and 8-bit fine fields.
// - Coarse gain bits are additive weights; several may be set.
// - Medium and fine gain have 256 steps, 0x80 means no change.
// - Core zero medium and fine gain writes apply only while adjust-enable is high.
// - Power field: 000 pin, 001 normal, 010 nap, 100 sleep.
// - Register power mode is per indexed core; pin selection is global.
// - Power, divider and output format A registers survive soft reset.
// - Core one has identical trims, also gated by adjust-enable.
// - Writing 0 then 1 to clock-advance bit 0 slips output clock one period.
// - Divider field: 000 pin, 001 divide one, 010 divide two; others not allowed.
// - Output mode bits 7:5: 000 diff 3 mA, 001 diff 2 mA, 100 CMOS.
// - Coding bits 2:0: 000 two's complement, 010 Gray, 100 offset binary.
// - Format B bit 6 selects DLL range, fast by default.
// - Calibration status bit 0 reads 0 while calibrating, 1 once done.
// - Only calibration status is readable before calibration completes.
// - Test mode 7:4: off, midscale, plus full, minus full, user, ramp.
// - User pattern mode replays user words up to depth in bits 2:0.
// - Test mode changes may take several sample cycles to appear.
// - Soft reset bit returns registers to defaults except exempted ones.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.vh"

module adc_config_register_bank (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    input  wire [1:0]  core_select,
    input  wire        cal_complete,
    input  wire [39:0] cal_core0,
    input  wire [39:0] cal_core1,
    input  wire [2:0]  power_state_pin,
    input  wire [2:0]  divider_select_pin,
    output reg  [39:0] applied_core0,
    output reg  [39:0] applied_core1,
    output reg  [2:0]  power_mode_core0,
    output reg  [2:0]  power_mode_core1,
    output reg  [2:0]  divider_mode,
    output reg         clock_advance,
    output reg  [2:0]  drive_mode,
    output reg  [2:0]  coding_mode,
    output reg         dll_slow,
    output reg         test_active,
    output reg  [15:0] test_word
);

// ****************************************
// Storage
// ****************************************
reg [7:0]  trim [0:9];
reg [7:0]  user_word [0:15];
reg [2:0]  power_sel0;
reg [2:0]  power_sel1;
reg [7:0]  output_clock_advance;
reg [7:0]  sample_clock_divider;
reg [7:0]  output_format_a;
reg [7:0]  output_format_b;
reg [7:0]  test_pattern_select;
reg [7:0]  adjust_enable;
reg        cal_seen;
reg        cal_loaded;
reg [2:0]  pat_index;
reg [15:0] ramp;
reg [2:0]  next_divider;
integer    i;

// ****************************************
// Helper functions
// ****************************************
// Trim index 0..4 core zero, 5..9 core one; 15 means not a trim
function [3:0] trim_index;
    input [7:0] a;
    begin
        if (a >= `ADDR_CORE0_OFFSET_C && a <= `ADDR_CORE0_GAIN_F)
            trim_index = a[3:0];
        else if (a >= `ADDR_CORE1_OFFSET_C && a <= `ADDR_CORE1_GAIN_F)
            trim_index = a[3:0] - 4'h1;
        else
            trim_index = 4'hf;
    end
endfunction

// Pack five trims of a core, offset coarse in the top byte
function [39:0] pack_core;
    input [7:0] oc;
    input [7:0] of;
    input [7:0] gc;
    input [7:0] gm;
    input [7:0] gf;
    begin
        pack_core = {oc, of, gc, gm, gf};
    end
endfunction

// Register-selected power state, or the global pin when field is zero
function [2:0] power_effective;
    input [2:0] sel;
    input [2:0] pin;
    begin
        power_effective = (sel == `PWR_PIN) ? pin : sel;
    end
endfunction

// ****************************************
// Address decode
// ****************************************
wire [3:0] wr_trim     = trim_index(reg_addr);
wire       soft_reset  = reg_wr && reg_addr == `ADDR_PORT_CONFIG && reg_wdata[`BIT_SOFT_RESET];
wire       cal_rise    = cal_complete && !cal_seen;
wire       user_hit    = reg_addr >= `ADDR_USER_FIRST && reg_addr <= `ADDR_USER_LAST;
// Last user byte 0xd0 wraps to index 15
wire [3:0] user_idx    = reg_addr[3:0] - 4'h1;
wire [7:0] core0_offc  = cal_core0[39:32];
wire       adjust_on   = adjust_enable[0];
wire [3:0] test_mode   = test_pattern_select[7:4];

// ****************************************
// Register writes and soft reset
// ****************************************
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        for (i = 0; i < 10; i = i + 1) begin
            trim[i] <= `TRIM_MID;
        end
        trim[2] <= `GAIN_COARSE_ZERO;
        trim[7] <= `GAIN_COARSE_ZERO;
        for (i = 0; i < 16; i = i + 1) begin
            user_word[i] <= `REG_ZERO;
        end
        power_sel0           <= `PWR_PIN;
        power_sel1           <= `PWR_PIN;
        output_clock_advance <= `REG_ZERO;
        sample_clock_divider <= `REG_ZERO;
        output_format_a      <= `REG_ZERO;
        output_format_b      <= `REG_ZERO;
        test_pattern_select  <= `REG_ZERO;
        adjust_enable        <= `REG_ZERO;
        clock_advance        <= 1'b0;
    end else begin
        clock_advance <= 1'b0;
        if (cal_rise || (soft_reset && cal_loaded)) begin
            // Self-calibration result becomes the trim default
            trim[0] <= cal_core0[39:32];
            trim[1] <= cal_core0[31:24];
            trim[2] <= cal_core0[23:16];
            trim[3] <= cal_core0[15:8];
            trim[4] <= cal_core0[7:0];
            trim[5] <= cal_core1[39:32];
            trim[6] <= cal_core1[31:24];
            trim[7] <= cal_core1[23:16];
            trim[8] <= cal_core1[15:8];
            trim[9] <= cal_core1[7:0];
        end
        if (soft_reset) begin
            // Power, divider and format A are kept
            for (i = 0; i < 16; i = i + 1) begin
                user_word[i] <= `REG_ZERO;
            end
            output_clock_advance <= `REG_ZERO;
            output_format_b      <= `REG_ZERO;
            test_pattern_select  <= `REG_ZERO;
            adjust_enable        <= `REG_ZERO;
        end else if (reg_wr && !cal_rise) begin
            // Writes on the calibration edge are dropped
            if (wr_trim != 4'hf)
                trim[wr_trim] <= reg_wdata;
            if (user_hit)
                user_word[user_idx] <= reg_wdata;
            case (reg_addr)
                `ADDR_POWER_STATE: begin
                    if (core_select[0])
                        power_sel0 <= reg_wdata[2:0];
                    if (core_select[1])
                        power_sel1 <= reg_wdata[2:0];
                end
                `ADDR_CLOCK_ADVANCE: begin
                    output_clock_advance <= reg_wdata;
                    if (reg_wdata[0] && !output_clock_advance[0])
                        clock_advance <= 1'b1;
                end
                `ADDR_CLOCK_DIVIDER: sample_clock_divider <= reg_wdata;
                `ADDR_FORMAT_A:      output_format_a      <= reg_wdata;
                `ADDR_FORMAT_B:      output_format_b      <= reg_wdata;
                `ADDR_TEST_SELECT:   test_pattern_select  <= reg_wdata;
                `ADDR_ADJUST_ENABLE: adjust_enable        <= reg_wdata;
                default: ;
            endcase
        end
    end
end

// ****************************************
// Calibration edge and status
// ****************************************
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        cal_seen   <= 1'b0;
        cal_loaded <= 1'b0;
    end else begin
        cal_seen <= cal_complete;
        // Status stays set from the first completion on
        if (cal_rise)
            cal_loaded <= 1'b1;
    end
end

// ****************************************
// Trim application to the cores
// ****************************************
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        applied_core0 <= {`TRIM_MID, `TRIM_MID, `GAIN_COARSE_ZERO, `TRIM_MID, `TRIM_MID};
        applied_core1 <= {`TRIM_MID, `TRIM_MID, `GAIN_COARSE_ZERO, `TRIM_MID, `TRIM_MID};
    end else begin
        // Coarse gain follows its register directly
        applied_core0[23:16] <= {4'h0, trim[2][3:0]};
        applied_core1[23:16] <= {4'h0, trim[7][3:0]};
        if (cal_rise) begin
            applied_core0 <= pack_core(core0_offc, cal_core0[31:24], {4'h0, cal_core0[19:16]},
                                       cal_core0[15:8], cal_core0[7:0]);
            applied_core1 <= pack_core(cal_core1[39:32], cal_core1[31:24], {4'h0, cal_core1[19:16]},
                                       cal_core1[15:8], cal_core1[7:0]);
        end else if (adjust_on) begin
            applied_core0[39:24] <= {trim[0], trim[1]};
            applied_core0[15:0]  <= {trim[3], trim[4]};
            applied_core1[39:24] <= {trim[5], trim[6]};
            applied_core1[15:0]  <= {trim[8], trim[9]};
        end
        // Enable low: applied offsets and medium and fine gains hold
    end
end

// ****************************************
// Mode outputs
// ****************************************
// Illegal divider codes keep the previous choice
always @* begin
    next_divider = divider_mode;
    case (sample_clock_divider[2:0])
        `DIV_PIN:    next_divider = divider_select_pin;
        `DIV_BY_ONE: next_divider = `DIV_BY_ONE;
        `DIV_BY_TWO: next_divider = `DIV_BY_TWO;
        default:     next_divider = divider_mode;
    endcase
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        power_mode_core0 <= `PWR_NORMAL;
        power_mode_core1 <= `PWR_NORMAL;
        divider_mode     <= `DIV_BY_ONE;
        drive_mode       <= 3'b000;
        coding_mode      <= 3'b000;
        dll_slow         <= 1'b0;
    end else begin
        power_mode_core0 <= power_effective(power_sel0, power_state_pin);
        power_mode_core1 <= power_effective(power_sel1, power_state_pin);
        divider_mode <= next_divider;
        drive_mode  <= output_format_a[7:5];
        coding_mode <= output_format_a[2:0];
        dll_slow    <= output_format_b[`BIT_DLL_SLOW];
    end
end

// ****************************************
// Test pattern generator
// ****************************************
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        test_active <= 1'b0;
        test_word   <= `WORD_NEG;
        pat_index   <= 3'd0;
        ramp        <= 16'h0000;
    end else begin
        test_active <= test_mode != `TEST_OFF;
        ramp        <= ramp + 16'h0001;
        // Registered output adds latency, tolerated by users
        case (test_mode)
            `TEST_MID:  test_word <= `WORD_MID;
            `TEST_POS:  test_word <= `WORD_POS;
            `TEST_NEG:  test_word <= `WORD_NEG;
            `TEST_USER: begin
                test_word <= {user_word[{pat_index, 1'b1}], user_word[{pat_index, 1'b0}]};
                if (pat_index >= test_pattern_select[2:0])
                    pat_index <= 3'd0;
                else
                    pat_index <= pat_index + 3'd1;
            end
            `TEST_RAMP: test_word <= ramp;
            default:    test_word <= `WORD_NEG;
        endcase
        if (test_mode != `TEST_USER)
            pat_index <= 3'd0;
    end
end

// ****************************************
// Register reads
// ****************************************
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata  <= `REG_ZERO;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_rd;
        reg_rdata  <= `REG_ZERO;
        if (reg_rd && reg_addr == `ADDR_CAL_DONE)
            reg_rdata <= {7'h00, cal_loaded};
        else if (reg_rd && cal_loaded) begin
            if (wr_trim != 4'hf)
                reg_rdata <= trim[wr_trim];
            else if (user_hit)
                reg_rdata <= user_word[user_idx];
            else begin
                case (reg_addr)
                    `ADDR_POWER_STATE:   reg_rdata <= {5'h00, core_select[0] ? power_sel0 : power_sel1};
                    `ADDR_CLOCK_ADVANCE: reg_rdata <= output_clock_advance;
                    `ADDR_CLOCK_DIVIDER: reg_rdata <= sample_clock_divider;
                    `ADDR_FORMAT_A:      reg_rdata <= output_format_a;
                    `ADDR_FORMAT_B:      reg_rdata <= output_format_b;
                    `ADDR_TEST_SELECT:   reg_rdata <= test_pattern_select;
                    `ADDR_ADJUST_ENABLE: reg_rdata <= adjust_enable;
                    default:             reg_rdata <= `REG_ZERO;
                endcase
            end
        end
    end
end

endmodule // adc_config_register_bank

`default_nettype wire

// ---- tb/cfg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ****************
    // Byte access, idle bus shows inverted junk
    // ****************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    task automatic set_dll(input logic slow);
        logic [7:0] v;
        rd(8'h74, v);
        wr(8'h74, {v[7], slow, v[5:0]});
    endtask
    task automatic trim(input logic [7:0] a, input logic [7:0] d);
        wr(8'hfe, 8'h00);
        wr(a, d);
        wr(8'hfe, 8'h01);
        wr(8'hfe, 8'h00);
    endtask
    task automatic slip();
        wr(8'h71, 8'h00);
        wr(8'h71, 8'h01);
    endtask
endmodule // cfg_host_model
`default_nettype wire

// ---- tb/adc_cfg_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        cal_complete,
    input wire logic [39:0] applied_core0,
    input wire logic [39:0] applied_core1,
    input wire logic        clock_advance,
    input wire logic [2:0]  drive_mode,
    input wire logic [2:0]  coding_mode
);
    logic       adj_en;
    logic [1:0] calm;
    wire        soft_wr = reg_wr && reg_addr == 8'h00 && reg_wdata[5];
    wire        slip_wr = reg_wr && reg_addr == 8'h71 && reg_wdata[0];
    wire        wr_ok = reg_wr && calm == 2'd3;
    // ****************
    // Enable shadow, settle count after calibration or soft reset
    // ****************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            adj_en <= 1'b0;
            calm <= 2'd0;
        end else begin
            if (soft_wr)
                adj_en <= 1'b0;
            else if (reg_wr && reg_addr == 8'hfe)
                adj_en <= reg_wdata[0];
            if (soft_wr || $changed(cal_complete))
                calm <= 2'd0;
            else if (calm != 2'd3)
                calm <= calm + 2'd1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_pre_cal_zero: assert property (reg_rd && !cal_complete && reg_addr != 8'hb6
        |=> reg_rdata == 8'h00) else $error("Data read before calibration");
    chk_cal_status: assert property (reg_rd && reg_addr == 8'hb6 && calm == 2'd3
        |=> reg_rvalid && reg_rdata == {7'h00, cal_complete}) else $error("Bad calibration status");
    chk_trim_hold: assert property (!adj_en && calm == 2'd3 && !$changed(cal_complete)
        |=> $stable({applied_core0[39:24], applied_core0[15:0], applied_core1[39:24], applied_core1[15:0]}))
        else $error("Trim moved");
    chk_offset_apply: assert property (wr_ok && reg_addr == 8'h20 && adj_en
        |=> ##1 applied_core0[39:32] == $past(reg_wdata, 2)) else $error("Offset not applied");
    chk_core1_apply: assert property (wr_ok && reg_addr == 8'h27 && adj_en
        |=> ##1 applied_core1[31:24] == $past(reg_wdata, 2)) else $error("Core one trim not applied");
    chk_coarse_follow: assert property (wr_ok && reg_addr == 8'h22
        |=> ##1 applied_core0[23:16] == ($past(reg_wdata, 2) & 8'h0f)) else $error("Coarse gain wrong");
    chk_format_a: assert property (wr_ok && reg_addr == 8'h73
        |=> ##1 {drive_mode, 2'b00, coding_mode} == ($past(reg_wdata, 2) & 8'he7)) else $error("Format wrong");
    chk_clock_slip: assert property (clock_advance
        |-> ($past(slip_wr) || $past(slip_wr, 2)) ##1 !clock_advance) else $error("Stray clock slip");
    cover property (clock_advance);
    cover property (reg_rvalid && reg_rdata == 8'h01);
    cover property ($rose(adj_en));
endmodule // adc_cfg_checker
bind adc_config_register_bank adc_cfg_checker i_adc_cfg_checker (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cal_complete(cal_complete), .applied_core0(applied_core0),
    .applied_core1(applied_core1), .clock_advance(clock_advance), .drive_mode(drive_mode),
    .coding_mode(coding_mode));
`default_nettype wire

// ---- tb/adc_config_register_bank_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_bench;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [1:0]  core_select = 2'b01;
    logic        cal_complete = 1'b0;
    logic [39:0] cal_core0 = 40'h0;
    logic [39:0] cal_core1 = 40'h0;
    logic [2:0]  power_state_pin = 3'b001;
    logic [2:0]  divider_select_pin = 3'b010;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, reg_rvalid, clock_advance, dll_slow, test_active;
    wire  [39:0] applied_core0, applied_core1;
    wire  [2:0]  power_mode_core0, power_mode_core1, divider_mode, drive_mode, coding_mode;
    wire  [15:0] test_word;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          n_slip = 0;
    logic [7:0]  v;
    logic [15:0] w0;
    logic [2:0]  pw [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
    logic [2:0]  dv [4] = '{3'b000, 3'b001, 3'b011, 3'b010};
    logic [2:0]  dx [4] = '{3'b010, 3'b001, 3'b001, 3'b010};
    logic [15:0] tw [3] = '{16'h8000, 16'hffff, 16'h0000};

    cfg_host_model i_cfg_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    adc_config_register_bank i_adc_config_register_bank (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .core_select(core_select), .cal_complete(cal_complete), .cal_core0(cal_core0),
        .cal_core1(cal_core1), .power_state_pin(power_state_pin), .divider_select_pin(divider_select_pin),
        .applied_core0(applied_core0), .applied_core1(applied_core1), .power_mode_core0(power_mode_core0),
        .power_mode_core1(power_mode_core1), .divider_mode(divider_mode), .clock_advance(clock_advance),
        .drive_mode(drive_mode), .coding_mode(coding_mode), .dll_slow(dll_slow), .test_active(test_active),
        .test_word(test_word));

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (clock_advance === 1'b1) n_slip <= n_slip + 1;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    // ****************
    // Access and compare helpers
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_cfg_host_model.wr(a, d);
    endtask
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_cfg_host_model.rd(a, v);
        check(40'(v), 40'(e));
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        step(3);
        arst_n <= 1'b1;
        step(1);
        rchk(8'h20, 8'h00);
        rchk(8'hb6, 8'h00);
        cal_core0 <= 40'h11_22_0c_33_44;
        cal_core1 <= 40'h55_66_03_77_88;
        cal_complete <= 1'b1;
        step(4);
        rchk(8'hb6, 8'h01);
        rchk(8'h20, 8'h11);
        check(applied_core1, 40'h55_66_03_77_88);
        wr(8'h50, 8'hff);
        rchk(8'h50, 8'h00);
        $display("test calibration done");
        wr(8'h20, 8'h00);
        wr(8'h22, 8'h05);
        wr(8'h24, 8'hff);
        wr(8'h29, 8'h80);
        check(applied_core0, 40'h11_22_05_33_44);
        wr(8'hfe, 8'h01);
        step(1);
        check(applied_core0, 40'h00_22_05_33_ff);
        check(applied_core1, 40'h55_66_03_80_88);
        wr(8'h20, 8'h80);
        wr(8'h27, 8'hff);
        step(1);
        check(40'({applied_core0[39:32], applied_core1[31:24]}), 40'h80ff);
        i_cfg_host_model.trim(8'h21, 8'h7f);
        check(40'(applied_core0[31:24]), 40'h7f);
        $display("test trims done");
        core_select <= 2'b10;
        wr(8'h25, 8'h04);
        power_state_pin <= 3'b010;
        core_select <= 2'b01;
        foreach (pw[i]) begin
            wr(8'h25, {5'h00, pw[i]});
            step(1);
            check(40'(power_mode_core0), 40'(pw[i] == 3'b000 ? 3'b010 : pw[i]));
            check(40'(power_mode_core1), 40'(3'b100));
        end
        foreach (dv[i]) begin
            wr(8'h72, {5'h00, dv[i]});
            step(1);
            check(40'(divider_mode), 40'(dx[i]));
        end
        $display("test modes done");
        wr(8'h73, 8'h24);
        i_cfg_host_model.set_dll(1'b1);
        step(2);
        check(40'({drive_mode, coding_mode, dll_slow}), 40'({3'b001, 3'b100, 1'b1}));
        rchk(8'h74, 8'h40);
        foreach (tw[i]) begin
            wr(8'hc0, {4'(i + 1), 4'h0});
            step(3);
            check(40'({test_active, test_word}), 40'({1'b1, tw[i]}));
        end
        wr(8'h00, 8'h20);
        step(2);
        check(40'({divider_mode, drive_mode, coding_mode, power_mode_core0}), 40'h464);
        check(40'({dll_slow, test_active}), 40'h0);
        rchk(8'h20, 8'h11);
        $display("test soft reset done");
        wr(8'hc1, 8'h34);
        wr(8'hc2, 8'h12);
        wr(8'hc3, 8'h78);
        wr(8'hc4, 8'h56);
        wr(8'hc0, 8'h81);
        step(3);
        w0 = test_word;
        step(1);
        check(40'(test_word ^ w0), 40'(16'h444c));
        check(40'(w0 == 16'h1234 || w0 == 16'h5678), 40'h1);
        wr(8'hc0, 8'ha0);
        step(3);
        w0 = test_word;
        step(1);
        check(40'(test_word), 40'(w0 + 16'h0001));
        $display("test patterns done");
        i_cfg_host_model.slip();
        wr(8'h71, 8'h01);
        step(2);
        check(40'(n_slip), 40'h1);
        $display("test slip done");
        wrap_up();
    end
endmodule // adc_config_register_bank_bench
`default_nettype wire
